// ### rtl/watchdog_timeout_control_map.vh
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_TIMEOUT_CONTROL_MAP_VH
`define WATCHDOG_TIMEOUT_CONTROL_MAP_VH

// ----------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------
`define WD_ADDR_CTRL      5'h00
`define WD_ADDR_CAUSE     5'h04
`define WD_ADDR_STAT      5'h08
`define WD_ADDR_MASK      5'h0c

// ----------------------------------------------------------------
// watchdog_control_status fields
// ----------------------------------------------------------------
`define WD_B_IRQ_FLAG     7
`define WD_B_IRQ_EN       6
`define WD_B_TSEL3        5
`define WD_B_CE           4
`define WD_B_WDE          3
`define WD_B_TSEL_HI      2
`define WD_B_TSEL_LO      0

// reset_cause_register field
`define WD_B_CAUSE        3

// event status / mask fields
`define WD_S_IRQ          0
`define WD_S_RST          1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WD_TSEL_RST       4'h0
`define WD_STAT_RST       2'h0
`define WD_MASK_RST       2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WD_CE_CYCLES      3'h4
`define WD_CLK_HZ         40000000
`define WD_OSC_HZ         128000
`define WD_BASE_CYCLES    21'h000800
`define WD_MAX_CODE       4'h9

`endif

// ### rtl/watchdog_timeout_control.v
// watchdog time-out control with change-enable sequence and Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "watchdog_timeout_control_map.vh"

// Operation
// R1: protected changes need change-enable set first
// R2: change-enable clears itself after four cycles
// R3: reset-cause flag forces reset-enable to one
// R4: software clears cause flag before disabling reset
// R5: four-bit time-out select on bits 5,2..0
// R6: codes 0-9 give 2048 doubling cycles
// R7: oscillator ticks count; restart returns to zero
// R8: enable bits select mode; fuse forces reset
// R9: time-out sets flag; vector or one clears
// R10: combined mode: vector leaves reset; else reset
module watchdog_timeout_control #(
    parameter OSC_DIV = `WD_CLK_HZ / `WD_OSC_HZ
) (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire [4:0]  address_i,
    input  wire        read_i,
    input  wire        write_i,
    input  wire [31:0] writedata_i,
    input  wire [3:0]  byteenable_i,
    output reg  [31:0] readdata_o,
    output reg         waitrequest_o,
    input  wire        restart_i,
    input  wire        vector_ack_i,
    input  wire        always_on_fuse_i,
    output reg         vector_req_o,
    output reg         sys_reset_o,
    output reg         irq_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam CNT_W = 21;
    localparam DIV_W = 16;

    reg [DIV_W-1:0] div_reg;
    reg             tick_reg;
    reg [CNT_W-1:0] cnt_reg;
    reg             reset_enable_bit_reg;
    reg             dog_irq_enable_reg;
    reg             dog_irq_flag_reg;
    reg [3:0]       timeout_select_reg;
    reg             change_enable_bit_reg;
    reg [2:0]       ce_cnt_reg;
    reg             dog_reset_cause_flag_reg;
    reg [1:0]       stat_reg;
    reg [1:0]       mask_reg;

    // ----------------------------------------------------------------
    // time-out length per select code
    // ----------------------------------------------------------------
    function [CNT_W-1:0] limit_of;
        input [3:0] code;
        reg   [3:0] c;
        begin
            // reserved codes behave as the longest time-out
            c = (code > `WD_MAX_CODE) ? `WD_MAX_CODE : code;
            limit_of = `WD_BASE_CYCLES << c; // see R6
        end
    endfunction

    // ----------------------------------------------------------------
    // effective mode
    // ----------------------------------------------------------------
    wire reset_enable_eff;
    wire irq_enable_eff;
    wire running;

    assign reset_enable_eff = always_on_fuse_i | dog_reset_cause_flag_reg | reset_enable_bit_reg; // see R3
    assign irq_enable_eff   = dog_irq_enable_reg & ~always_on_fuse_i; // see R8
    assign running          = reset_enable_eff | irq_enable_eff; // see R8

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire       req;
    wire       wr_fire;
    wire       wr_ctrl;
    wire       wr_cause;
    wire       wr_stat;
    wire       wr_mask;
    wire [7:0] wd;
    wire [7:0] ctrl_view;

    assign req      = (read_i | write_i) & waitrequest_o;
    assign wr_fire  = write_i & ~waitrequest_o & byteenable_i[0];
    assign wr_ctrl  = wr_fire & (address_i == `WD_ADDR_CTRL);
    assign wr_cause = wr_fire & (address_i == `WD_ADDR_CAUSE);
    assign wr_stat  = wr_fire & (address_i == `WD_ADDR_STAT);
    assign wr_mask  = wr_fire & (address_i == `WD_ADDR_MASK);
    assign wd       = writedata_i[7:0];

    assign ctrl_view = {dog_irq_flag_reg, irq_enable_eff, timeout_select_reg[3], change_enable_bit_reg,
                        reset_enable_eff, timeout_select_reg[2:0]};

    // ----------------------------------------------------------------
    // time-out detection
    // ----------------------------------------------------------------
    wire [CNT_W-1:0] limit_now;
    wire             to_hit;
    wire             irq_act;
    wire             rst_act;

    assign limit_now = limit_of(timeout_select_reg); // see R5
    assign to_hit    = running & tick_reg & ~restart_i & (cnt_reg == limit_now - 21'h000001); // see R7
    // combined mode with the flag still pending goes straight to reset
    assign irq_act   = to_hit & irq_enable_eff & ~(reset_enable_eff & dog_irq_flag_reg); // see R9
    assign rst_act   = to_hit & reset_enable_eff & (~irq_enable_eff | dog_irq_flag_reg); // see R10

    // ----------------------------------------------------------------
    // bus slave: one wait state, then one cycle with waitrequest low
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h00000000;
        end else begin
            if (req) begin
                waitrequest_o <= 1'b0;
                if (read_i) begin
                    case (address_i)
                        `WD_ADDR_CTRL:  readdata_o <= {24'h000000, ctrl_view};
                        `WD_ADDR_CAUSE: readdata_o <= {28'h0000000, dog_reset_cause_flag_reg, 3'h0};
                        `WD_ADDR_STAT:  readdata_o <= {30'h0, stat_reg};
                        `WD_ADDR_MASK:  readdata_o <= {30'h0, mask_reg};
                        default:        readdata_o <= 32'h00000000;
                    endcase
                end else begin
                    readdata_o <= 32'h00000000;
                end
            end else begin
                waitrequest_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // oscillator tick divider
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            div_reg  <= {DIV_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (div_reg == OSC_DIV[DIV_W-1:0] - 16'h0001) begin
            div_reg  <= {DIV_W{1'b0}};
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // watchdog counter
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            cnt_reg <= {CNT_W{1'b0}};
        end else if (restart_i | ~running | to_hit | rst_act) begin
            cnt_reg <= {CNT_W{1'b0}}; // see R7
        end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 21'h000001; // see R7
        end
    end

    // ----------------------------------------------------------------
    // control bits; later assignments win, so hardware sets beat clears
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            reset_enable_bit_reg  <= 1'b0;
            dog_irq_enable_reg    <= 1'b0;
            dog_irq_flag_reg      <= 1'b0;
            timeout_select_reg    <= `WD_TSEL_RST;
            change_enable_bit_reg <= 1'b0;
            ce_cnt_reg            <= 3'h0;
        end else begin
            if (ce_cnt_reg != 3'h0) begin
                ce_cnt_reg <= ce_cnt_reg - 3'h1;
            end
            if (change_enable_bit_reg & (ce_cnt_reg == 3'h1)) begin
                change_enable_bit_reg <= 1'b0; // see R2
            end
            if (vector_ack_i) begin
                dog_irq_flag_reg <= 1'b0; // see R9
                if (reset_enable_eff) begin
                    dog_irq_enable_reg <= 1'b0; // see R10
                end
            end
            if (wr_ctrl) begin
                if (change_enable_bit_reg) begin
                    reset_enable_bit_reg <= wd[`WD_B_WDE]; // see R1
                    timeout_select_reg   <= {wd[`WD_B_TSEL3], wd[`WD_B_TSEL_HI:`WD_B_TSEL_LO]}; // see R5
                end else if (wd[`WD_B_WDE]) begin
                    reset_enable_bit_reg <= 1'b1; // see R1
                end
                dog_irq_enable_reg <= wd[`WD_B_IRQ_EN];
                if (wd[`WD_B_IRQ_FLAG]) begin
                    dog_irq_flag_reg <= 1'b0; // see R9
                end
                if (wd[`WD_B_CE] & wd[`WD_B_WDE]) begin
                    change_enable_bit_reg <= 1'b1; // see R2
                    ce_cnt_reg            <= `WD_CE_CYCLES; // see R2
                end
            end
            if (irq_act) begin
                dog_irq_flag_reg <= 1'b1; // see R9
            end
            if (rst_act) begin
                // system reset returns the set-up to its reset values, except reset-enable, which is set to one below
                dog_irq_enable_reg    <= 1'b0;
                dog_irq_flag_reg      <= 1'b0;
                timeout_select_reg    <= `WD_TSEL_RST;
                change_enable_bit_reg <= 1'b0;
                ce_cnt_reg            <= 3'h0;
            end
            // the stored bit stays one, so clearing the cause flag alone never disarms the reset
            if (dog_reset_cause_flag_reg | rst_act) begin
                reset_enable_bit_reg <= 1'b1; // see R3
            end
        end
    end

    // ----------------------------------------------------------------
    // reset cause flag; cleared by writing zero, set by a watchdog reset
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            dog_reset_cause_flag_reg <= 1'b0;
        end else begin
            if (wr_cause & ~wd[`WD_B_CAUSE]) begin
                dog_reset_cause_flag_reg <= 1'b0; // see R4
            end
            if (rst_act) begin
                dog_reset_cause_flag_reg <= 1'b1; // see R3
            end
        end
    end

    // ----------------------------------------------------------------
    // event status, mask and outputs
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            stat_reg     <= `WD_STAT_RST;
            mask_reg     <= `WD_MASK_RST;
            irq_o        <= 1'b0;
            vector_req_o <= 1'b0;
            sys_reset_o  <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_reg <= wd[1:0];
            end
            stat_reg <= (stat_reg & ~(wr_stat ? wd[1:0] : 2'h0)) | {rst_act, irq_act};
            irq_o        <= |(stat_reg & mask_reg);
            vector_req_o <= dog_irq_flag_reg & irq_enable_eff; // see R9
            sys_reset_o  <= rst_act; // see R10
        end
    end

endmodule // watchdog_timeout_control

// ### verif/watchdog_timeout_control_sva.sv
// assertion checker for the watchdog port behaviour
`timescale 1ns/1ps
module watchdog_timeout_control_sva #(
    parameter OSC_DIV = 312
) (
    input wire        clk_i,
    input wire        reset_i,
    input wire [4:0]  address_i,
    input wire        read_i,
    input wire        write_i,
    input wire [31:0] writedata_i,
    input wire [3:0]  byteenable_i,
    input wire [31:0] readdata_o,
    input wire        waitrequest_o,
    input wire        restart_i,
    input wire        vector_ack_i,
    input wire        always_on_fuse_i,
    input wire        vector_req_o,
    input wire        sys_reset_o,
    input wire        irq_o
);
    reg  [2:0]  ce_age;
    reg  [31:0] since_rst;
    wire        ctrl_rd = !waitrequest_o && read_i && address_i == 5'h00;
    wire        opener  = !waitrequest_o && write_i && address_i == 5'h00 && byteenable_i[0]
                          && writedata_i[4] && writedata_i[3];
    // ----------------------------------------
    // age of the change window and of the count
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) ce_age <= 3'h7;
        else if (opener) ce_age <= 3'h0;
        else if (ce_age != 3'h7) ce_age <= ce_age + 3'h1;
        if (reset_i || restart_i) since_rst <= 32'h0;
        else if (since_rst != 32'hffffffff) since_rst <= since_rst + 32'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_wait_one: assert property (!waitrequest_o |=> waitrequest_o) else $error("wait low too long");
    a_answer_next: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o) else $error("late answer");
    a_upper_zero: assert property (!waitrequest_o && read_i |-> readdata_o[31:8] == 24'h0) else $error("upper bits");
    a_unmapped_zero: assert property (!waitrequest_o && read_i && (address_i[1:0] != 2'h0 || address_i > 5'h0c)
        |-> readdata_o == 32'h0) else $error("unmapped read");
    a_window_closes: assert property (ctrl_rd && ce_age == 3'h7 |-> !readdata_o[4]) else $error("window open");
    a_fuse_forces: assert property (ctrl_rd && always_on_fuse_i |-> readdata_o[3] && !readdata_o[6])
        else $error("fuse ignored");
    a_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o) else $error("reset pulse long");
    a_restart_defers: assert property (sys_reset_o || $rose(vector_req_o) |-> since_rst >= 2046 * OSC_DIV)
        else $error("early time-out");
endmodule // watchdog_timeout_control_sva
bind watchdog_timeout_control watchdog_timeout_control_sva #(.OSC_DIV(OSC_DIV)) watchdog_timeout_control_sva_i (
    .clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .restart_i(restart_i), .vector_ack_i(vector_ack_i),
    .always_on_fuse_i(always_on_fuse_i), .vector_req_o(vector_req_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o));

// ### verif/watchdog_timeout_control_tb.sv
// self-checking testbench of the watchdog control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module watchdog_timeout_control_tb;
    logic        clk_i = 0, reset_i = 1, read_i = 0, write_i = 0;
    logic        restart_i = 0, vector_ack_i = 0, always_on_fuse_i = 0;
    logic [4:0]  address_i = 5'h00;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0]  byteenable_i = 4'hf;
    wire  [31:0] readdata_o;
    wire         waitrequest_o, vector_req_o, sys_reset_o, irq_o;
    integer      error_cnt = 0, total_checks = 0, n;
    logic [7:0]  q;
    watchdog_timeout_control #(.OSC_DIV(2)) watchdog_timeout_control_i (.clk_i(clk_i), .reset_i(reset_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .restart_i(restart_i), .vector_ack_i(vector_ack_i), .always_on_fuse_i(always_on_fuse_i),
        .vector_req_o(vector_req_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // bus and helper tasks
    // ----------------------------------------
    task automatic xfer(input logic w, input [4:0] a, input [7:0] d, output [7:0] r);
        integer k;
        @(posedge clk_i);
        address_i <= a; writedata_i <= {24'h0, d}; write_i <= w; read_i <= !w;
        k = 0;
        do begin @(posedge clk_i); k++; end while (waitrequest_o !== 1'b0 && k < 50);
        r = readdata_o[7:0];
        write_i <= 1'b0; read_i <= 1'b0;
        if (k >= 50) begin error_cnt++; $display("CHECK FAILED at %0t: bus hang", $time); end
    endtask
    task automatic wr(input [4:0] a, input [7:0] d);
        logic [7:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rchk(input [4:0] a, input [7:0] e);
        xfer(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic restart;
        @(posedge clk_i); restart_i <= 1'b1;
        @(posedge clk_i); restart_i <= 1'b0;
    endtask
    task automatic wait_out(input logic sel);
        n = 0;
        while ((sel ? sys_reset_o : vector_req_o) !== 1'b1 && n < 20000) begin @(posedge clk_i); n++; end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle;
        rchk(5'h00, 8'h00); rchk(5'h04, 8'h00); rchk(5'h08, 8'h00); rchk(5'h10, 8'h00);
        byteenable_i <= 4'he; wr(5'h00, 8'h08); byteenable_i <= 4'hf; rchk(5'h00, 8'h00);
    endtask
    task automatic t_protect;
        wr(5'h00, 8'h08); wr(5'h00, 8'h00); rchk(5'h00, 8'h08);
        wr(5'h00, 8'h18); wr(5'h00, 8'h21); repeat (8) @(posedge clk_i);
        rchk(5'h00, 8'h21);
        wr(5'h00, 8'h07); rchk(5'h00, 8'h21);
        wr(5'h00, 8'h18); xfer(1'b0, 5'h00, 8'h00, q); `CHK(q[4], 1'b1)
        repeat (6) @(posedge clk_i); rchk(5'h00, 8'h29);
        wr(5'h00, 8'h18); wr(5'h00, 8'h00); rchk(5'h00, 8'h00);
    endtask
    task automatic t_irq;
        wr(5'h0c, 8'h00); wr(5'h00, 8'h40); repeat (3000) @(posedge clk_i);
        restart; wait_out(1'b0); `CHK(n >= 4090 && n <= 4105, 1'b1)
        `CHK(irq_o, 1'b0) rchk(5'h00, 8'hc0); rchk(5'h08, 8'h01);
        wr(5'h0c, 8'h01); repeat (2) @(posedge clk_i); `CHK(irq_o, 1'b1)
        wr(5'h08, 8'h01); repeat (2) @(posedge clk_i); `CHK(irq_o, 1'b0)
        @(posedge clk_i); vector_ack_i <= 1'b1; @(posedge clk_i); vector_ack_i <= 1'b0;
        repeat (2) @(posedge clk_i); `CHK(vector_req_o, 1'b0) rchk(5'h00, 8'h40);
        wr(5'h00, 8'h00);
    endtask
    task automatic t_combined;
        wr(5'h00, 8'h18); wr(5'h00, 8'h49); restart;
        wait_out(1'b0); `CHK(n >= 8186 && n <= 8200, 1'b1)
        wait_out(1'b1); `CHK(n >= 8180 && n <= 8200, 1'b1)
        rchk(5'h04, 8'h08); rchk(5'h00, 8'h08); xfer(1'b0, 5'h08, 8'h00, q); `CHK(q[1], 1'b1)
        restart; wr(5'h00, 8'h18); wr(5'h00, 8'h00); rchk(5'h00, 8'h08);
        wr(5'h04, 8'h00); rchk(5'h04, 8'h00); rchk(5'h00, 8'h08);
        wr(5'h00, 8'h18); wr(5'h00, 8'h00); rchk(5'h00, 8'h00);
    endtask
    task automatic t_fuse;
        always_on_fuse_i <= 1'b1; restart; rchk(5'h00, 8'h08);
        wr(5'h00, 8'h40); rchk(5'h00, 8'h08);
    endtask
    task automatic t_vector;
        wr(5'h08, 8'h03); wr(5'h0c, 8'h02); wr(5'h00, 8'h18); wr(5'h00, 8'h48); restart;
        wait_out(1'b0); `CHK(n >= 4090 && n <= 4105, 1'b1)
        `CHK(irq_o, 1'b0)
        @(posedge clk_i); vector_ack_i <= 1'b1; @(posedge clk_i); vector_ack_i <= 1'b0;
        rchk(5'h00, 8'h08);
        wait_out(1'b1); `CHK(n >= 4080 && n <= 4100, 1'b1)
        repeat (2) @(posedge clk_i); `CHK(irq_o, 1'b1)
        wr(5'h08, 8'h02); repeat (2) @(posedge clk_i); `CHK(irq_o, 1'b0)
        @(posedge clk_i); reset_i <= 1'b1; repeat (2) @(posedge clk_i); reset_i <= 1'b0;
        rchk(5'h04, 8'h00); rchk(5'h0c, 8'h00); rchk(5'h00, 8'h00);
    endtask
    task automatic t_flag_clear;
        wr(5'h00, 8'h40); restart; wait_out(1'b0); `CHK(n >= 4090 && n <= 4105, 1'b1)
        wr(5'h00, 8'h40); rchk(5'h00, 8'hc0);
        wr(5'h00, 8'hc0); rchk(5'h00, 8'h40);
        repeat (2) @(posedge clk_i); `CHK(vector_req_o, 1'b0)
        wr(5'h00, 8'h00);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_idle; t_protect; t_irq; t_combined; t_vector; t_flag_clear; t_fuse;
        close_out;
    end
    initial begin
        #(25 * 100000);
        error_cnt++;
        close_out;
    end
endmodule // watchdog_timeout_control_tb
